// File: rtl/srp_routing_power.sv
// Routing, power-down and PLL mode control behind the serial control port
`timescale 1ns/100ps
// Function
// - A three-bit selector picks which of eight receive inputs feeds clock and data recovery.
// - The transmit source bit picks recovered data on PLL clock B or audio port data on mclk.
// - The transmitter power-down bit disables the transmitter when set and resets set.
// - The oscillator power-down bit stops the oscillator clock when set and resets set.
// - The oscillator clock can be routed to the master clock pin and the aux clock output.
// - The PLL enters automatic mode whenever the receiver is enabled.
// - In automatic mode the receiver drives the PLL factors to track the stream.
// - PLL-sourced output clocks follow the incoming stream rate in automatic mode.
// - After a rate change the output clocks keep running but are invalid until lock.
// - When the stream stops the PLL factors freeze at the last recovered values.
// - With receive configured and no stream yet seen since enable the PLL defaults to roughly 24MHz.
// - With the receiver disabled the PLL uses the software factors and dividers.
// - In automatic mode the device sets the post divider, overriding software.
module srp_routing_power (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Decoded register access from the serial control port
  input  wire logic [6:0]  reg_index,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Receive inputs from pins
  input  wire logic [7:0]  receive_input,
  output logic             cdr_data,
  // Receiver side, same clock
  input  wire logic        receiver_enable,
  input  wire logic        stream_present,
  input  wire logic        rx_lock,
  input  wire logic [3:0]  rx_n,
  input  wire logic [21:0] rx_k,
  input  wire logic [1:0]  rx_post_divider,
  input  wire logic        recovered_data,
  // Software PLL settings from other registers
  input  wire logic [3:0]  sw_n,
  input  wire logic [21:0] sw_k,
  input  wire logic [1:0]  sw_post_divider,
  // Output clock routing requests
  input  wire logic        mclk_pin_is_output,
  input  wire logic [1:0]  mclk_source,
  input  wire logic        aux_clock_enable,
  input  wire logic [1:0]  aux_source,
  // Transmitter
  input  wire logic        audio_port_data,
  output logic             transmit_data,
  output logic             transmit_encode_clock_sel,
  output logic             transmitter_enable,
  // Power and clock outputs
  output logic             oscillator_enable,
  output logic             pll_enable,
  output logic             mclk_use_oscillator,
  output logic             aux_use_oscillator,
  output logic             output_clocks_valid,
  output logic             pll_auto_mode,
  output logic      [3:0]  pll_n,
  output logic      [21:0] pll_k,
  output logic      [1:0]  pll_post_divider
);
  logic [7:0] rxsel_r, rxsel_nxt;
  logic [7:0] tx4_r, tx4_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] rx_meta_r, rx_sync_r;
  logic       cdr_r, txd_r, cdr_nxt, txd_nxt;
  logic       clocks_valid;
  srp_pkg::srp_pll_state_t pll_state;

  // Shared decode of register index
  function automatic logic hit(input logic [6:0] idx, input logic [6:0] target);
    hit = (idx == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are masked off so they read zero
  always_comb
  begin
    rxsel_nxt = rxsel_r;
    tx4_nxt   = tx4_r;
    pwr_nxt   = pwr_r;
    if (reg_write)
    begin
      if (hit(reg_index, srp_pkg::REG_SOFT_RESET))
      begin
        // Soft reset returns everything to defaults, powering all down
        rxsel_nxt = srp_pkg::RXSEL_RST;
        tx4_nxt   = srp_pkg::TX4_RST;
        pwr_nxt   = srp_pkg::PWR_RST;
      end
      if (hit(reg_index, srp_pkg::REG_RX_INPUT_SEL))
        rxsel_nxt = reg_wdata & srp_pkg::RXSEL_MASK;
      if (hit(reg_index, srp_pkg::REG_TX_CTRL_FOUR))
        tx4_nxt = reg_wdata & srp_pkg::TX4_MASK;
      if (hit(reg_index, srp_pkg::REG_POWER_DOWN))
        pwr_nxt = reg_wdata & srp_pkg::PWR_MASK;
    end
  end

  // Read data is registered; unmapped indices read zero
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_read)
    begin
      unique case (reg_index)
        srp_pkg::REG_RX_INPUT_SEL: rdata_nxt = rxsel_r;
        srp_pkg::REG_TX_CTRL_FOUR: rdata_nxt = tx4_r;
        srp_pkg::REG_POWER_DOWN:   rdata_nxt = pwr_r;
        default:                   rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxsel_r <= srp_pkg::RXSEL_RST;
      tx4_r   <= srp_pkg::TX4_RST;
      pwr_r   <= srp_pkg::PWR_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      rxsel_r <= rxsel_nxt;
      tx4_r   <= tx4_nxt;
      pwr_r   <= pwr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the asynchronous receive pins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rx_sync
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          rx_meta_r[gi] <= 1'b0;
          rx_sync_r[gi] <= 1'b0;
        end
        else
        begin
          rx_meta_r[gi] <= receive_input[gi];
          rx_sync_r[gi] <= rx_meta_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data routing: input select and transmit source, both registered
  always_comb
  begin
    cdr_nxt = rx_sync_r[rxsel_r[srp_pkg::RXSEL_LSB +: srp_pkg::RXSEL_W]];
    if (pwr_r[srp_pkg::TXPD_BIT])
      txd_nxt = 1'b0;
    else if (tx4_r[srp_pkg::TRANSMIT_SOURCE_SELECT_BIT] == srp_pkg::TRANSMIT_SOURCE_SELECT_AUDIO_PORT)
      txd_nxt = audio_port_data;
    else
      txd_nxt = recovered_data;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cdr_r <= 1'b0;
      txd_r <= 1'b0;
    end
    else
    begin
      cdr_r <= cdr_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign cdr_data                  = cdr_r;
  assign transmit_data             = txd_r;
  // High selects mclk pin, low selects PLL clock B
  assign transmit_encode_clock_sel = tx4_r[srp_pkg::TRANSMIT_SOURCE_SELECT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Power enables straight from the register so they act on the write
  assign transmitter_enable = ~pwr_r[srp_pkg::TXPD_BIT];
  assign oscillator_enable  = ~pwr_r[srp_pkg::OSCILLATOR_POWERDOWN_BIT];
  assign pll_enable         = ~pwr_r[srp_pkg::PLL_POWERDOWN_BIT];
  assign pll_auto_mode      = receiver_enable;

  // Oscillator clock reaches pins only while it runs and the pin is configured
  assign mclk_use_oscillator = oscillator_enable & mclk_pin_is_output &
                               (mclk_source == srp_pkg::CLKSRC_OSC);
  assign aux_use_oscillator  = oscillator_enable & aux_clock_enable &
                               (aux_source == srp_pkg::CLKSRC_OSC);

  // In automatic mode PLL-sourced output clocks follow the stream; validity waits for lock
  srp_pll_mode u_pll_mode (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .auto_mode        (receiver_enable),
    .stream_present   (stream_present),
    .rx_lock          (rx_lock),
    .rx_n             (rx_n),
    .rx_k             (rx_k),
    .rx_post_divider  (rx_post_divider),
    .sw_n             (sw_n),
    .sw_k             (sw_k),
    .sw_post_divider  (sw_post_divider),
    .pll_n            (pll_n),
    .pll_k            (pll_k),
    .pll_post_divider (pll_post_divider),
    .clocks_valid     (clocks_valid),
    .pll_state        (pll_state)
  );
  assign output_clocks_valid = clocks_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_rxsel_route: assert property (
    ##2 cdr_data == $past(rx_sync_r[rxsel_r[2:0]]))
    else $error("cdr data not from selected input");
  a_transmit_source_select_path: assert property (
    (!pwr_r[2] && tx4_r[6]) |=> transmit_data == $past(audio_port_data))
    else $error("audio port data not routed to transmitter");
  a_tx_powerdown: assert property (
    $past(pwr_r[2]) |-> !transmit_data)
    else $error("transmitter active while powered down");
  a_pwr_write_effect: assert property (
    (reg_write && reg_index == 7'h1e) |=> pwr_r == ($past(reg_wdata) & 8'h0d))
    else $error("power register write wrong");
  a_reserved_zero: assert property (
    (reg_read && reg_index == 7'h15) |=> (reg_rdata & 8'hbf) == 8'h00)
    else $error("reserved bits read nonzero");
  a_osc_route: assert property (
    pwr_r[3] |-> !mclk_use_oscillator && !aux_use_oscillator)
    else $error("oscillator clock routed while powered down");
  a_manual_factors: assert property (
    (!receiver_enable ##1 !receiver_enable) |-> pll_n == $past(sw_n) &&
      pll_post_divider == $past(sw_post_divider))
    else $error("manual factors not applied");
  a_track_factors: assert property (
    (pll_state == srp_pkg::SRP_PLL_TRACK && receiver_enable && stream_present)
      |=> pll_k == $past(rx_k) && pll_post_divider == $past(rx_post_divider))
    else $error("tracking factors not applied");
  a_freeze_hold: assert property (
    (pll_state != srp_pkg::SRP_PLL_DEFAULT && receiver_enable && !stream_present)
      |=> $stable(pll_n) && $stable(pll_k))
    else $error("factors moved while frozen");
  a_invalid_unlock: assert property (
    (receiver_enable && pll_state == srp_pkg::SRP_PLL_TRACK && !rx_lock
      && stream_present) |=> !output_clocks_valid)
    else $error("clocks valid without lock");
  a_default_rate: assert property (
    (receiver_enable && pll_state == srp_pkg::SRP_PLL_DEFAULT)
      |=> pll_n == 4'h8 || !receiver_enable)
    else $error("default factors missing");

  c_tx_reroute: cover property (pwr_r[2] ##1 $changed(tx4_r[6]) ##[1:10] !pwr_r[2]);
  c_track_freeze: cover property (pll_state == srp_pkg::SRP_PLL_TRACK
    ##[1:20] pll_state == srp_pkg::SRP_PLL_FREEZE);
  c_sel_input7: cover property (rxsel_r[2:0] == 3'h7);
endmodule // srp_routing_power

// File: common/srp_pkg.sv
// Register map, field positions and reset values for S/PDIF routing and clock power control
package srp_pkg;
  // Register indices on the serial control port
  localparam logic [6:0] REG_SOFT_RESET   = 7'h00;
  localparam logic [6:0] REG_RX_INPUT_SEL = 7'h08;
  localparam logic [6:0] REG_TX_CTRL_FOUR = 7'h15;
  localparam logic [6:0] REG_POWER_DOWN   = 7'h1e;

  // Field positions
  localparam int RXSEL_LSB   = 0;
  localparam int RXSEL_W     = 3;
  localparam int TRANSMIT_SOURCE_SELECT_BIT   = 6;
  localparam int PLL_POWERDOWN_BIT   = 0;
  localparam int TXPD_BIT    = 2;
  localparam int OSCILLATOR_POWERDOWN_BIT   = 3;

  // Writable bit masks; all other bits are reserved
  localparam logic [7:0] RXSEL_MASK = 8'h07;
  localparam logic [7:0] TX4_MASK   = 8'h40;
  localparam logic [7:0] PWR_MASK   = 8'h0d;

  // Reset values
  localparam logic [7:0] RXSEL_RST = 8'h00;
  localparam logic [7:0] TX4_RST   = 8'h40;
  localparam logic [7:0] PWR_RST   = 8'h0d;

  // Transmit source encodings
  localparam logic TRANSMIT_SOURCE_SELECT_RECOVERED  = 1'b0;
  localparam logic TRANSMIT_SOURCE_SELECT_AUDIO_PORT = 1'b1;

  // Output clock source codes shared by master clock pin and aux clock output
  localparam logic [1:0] CLKSRC_OSC   = 2'h0;
  localparam logic [1:0] CLKSRC_PLL_A = 2'h1;
  localparam logic [1:0] CLKSRC_PLL_B = 2'h2;

  // PLL factor widths
  localparam int PLL_N_W   = 4;
  localparam int PLL_K_W   = 22;
  localparam int POSTDIV_W = 2;

  // PLL control modes
  typedef enum logic [1:0] {
    SRP_PLL_DEFAULT = 2'b00,
    SRP_PLL_TRACK   = 2'b01,
    SRP_PLL_FREEZE  = 2'b10
  } srp_pll_state_t;
endpackage

// File: rtl/srp_pll_mode.sv
// PLL factor selection: manual factors, automatic tracking, freeze and default
`timescale 1ns/100ps
module srp_pll_mode #(
  parameter logic [3:0]  DEF_N       = 4'h8,      // Factors giving roughly 24MHz output
  parameter logic [21:0] DEF_K       = 22'h000000,
  parameter logic [1:0]  DEF_POSTDIV = 2'h2
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        auto_mode,
  input  wire logic        stream_present,
  input  wire logic        rx_lock,
  input  wire logic [3:0]  rx_n,
  input  wire logic [21:0] rx_k,
  input  wire logic [1:0]  rx_post_divider,
  input  wire logic [3:0]  sw_n,
  input  wire logic [21:0] sw_k,
  input  wire logic [1:0]  sw_post_divider,
  output logic      [3:0]  pll_n,
  output logic      [21:0] pll_k,
  output logic      [1:0]  pll_post_divider,
  output logic             clocks_valid,
  output srp_pkg::srp_pll_state_t pll_state
);
  srp_pkg::srp_pll_state_t state_r, state_nxt;
  logic [3:0]  n_r, n_nxt;
  logic [21:0] k_r, k_nxt;
  logic [1:0]  pd_r, pd_nxt;
  logic        valid_r, valid_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next factors: manual when the receiver is off, else defaults, receiver values or held
  always_comb
  begin
    state_nxt = state_r;
    n_nxt     = n_r;
    k_nxt     = k_r;
    pd_nxt    = pd_r;
    valid_nxt = valid_r;
    if (!auto_mode)
    begin
      state_nxt = srp_pkg::SRP_PLL_DEFAULT;
      n_nxt     = sw_n;
      k_nxt     = sw_k;
      pd_nxt    = sw_post_divider;
      valid_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        srp_pkg::SRP_PLL_DEFAULT:
        begin
          n_nxt     = DEF_N;
          k_nxt     = DEF_K;
          pd_nxt    = DEF_POSTDIV;
          valid_nxt = 1'b0;
          if (stream_present)
            state_nxt = srp_pkg::SRP_PLL_TRACK;
        end
        srp_pkg::SRP_PLL_TRACK:
        begin
          // Stream loss holds the factors at once, so no stale receiver value slips in
          if (stream_present)
          begin
            n_nxt     = rx_n;
            k_nxt     = rx_k;
            pd_nxt    = rx_post_divider;
            valid_nxt = rx_lock;
          end
          else
            state_nxt = srp_pkg::SRP_PLL_FREEZE;
        end
        srp_pkg::SRP_PLL_FREEZE:
        begin
          // Factors hold so clocks keep the last recovered rate
          if (stream_present)
          begin
            state_nxt = srp_pkg::SRP_PLL_TRACK;
            valid_nxt = rx_lock;
          end
        end
        default:
          state_nxt = srp_pkg::SRP_PLL_DEFAULT;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= srp_pkg::SRP_PLL_DEFAULT;
      n_r     <= DEF_N;
      k_r     <= DEF_K;
      pd_r    <= DEF_POSTDIV;
      valid_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      n_r     <= n_nxt;
      k_r     <= k_nxt;
      pd_r    <= pd_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign pll_n            = n_r;
  assign pll_k            = k_r;
  assign pll_post_divider = pd_r;
  assign clocks_valid     = valid_r;
  assign pll_state        = state_r;
endmodule // srp_pll_mode

// File: verif/srp_host_model.sv
// Host controller model driving the decoded serial control port
`timescale 1ns/100ps
module srp_host_model (
  input  wire logic       core_clk,
  output logic      [6:0] reg_index,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero, no strobe before reset is released
  initial
  begin
    reg_index = 7'h7f;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One strobe per call; index and data hold through the taking edge
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] data);
    @(posedge core_clk);
    #10;
    reg_index = idx;
    reg_wdata = data;
    reg_write = 1'b1;
    @(posedge core_clk);
    #10;
    reg_write = 1'b0;
    reg_index = ~idx;  // Released lines never keep the last value
    reg_wdata = ~data;
  endtask

  // Read data is registered on the taking edge and holds afterwards
  task automatic read_reg(input logic [6:0] idx, output logic [7:0] data);
    @(posedge core_clk);
    #10;
    reg_index = idx;
    reg_read  = 1'b1;
    @(posedge core_clk);
    #10;
    reg_read  = 1'b0;
    reg_index = ~idx;
    data      = reg_rdata;
  endtask
endmodule // srp_host_model

// File: verif/srp_routing_power_tb.sv
// Self-checking testbench for routing, power-down and PLL mode control
`timescale 1ns/100ps
module srp_routing_power_tb;
  logic        core_clk, resetn, reg_write, reg_read, cdr_data, receiver_enable;
  logic        stream_present, rx_lock, recovered_data, mclk_pin_is_output;
  logic        aux_clock_enable, audio_port_data, transmit_data, transmit_encode_clock_sel;
  logic        transmitter_enable, oscillator_enable, pll_enable, mclk_use_oscillator;
  logic        aux_use_oscillator, output_clocks_valid, pll_auto_mode;
  logic [6:0]  reg_index;
  logic [7:0]  reg_wdata, reg_rdata, receive_input, pw;
  logic [3:0]  rx_n, sw_n, pll_n;
  logic [21:0] rx_k, sw_k, pll_k;
  logic [1:0]  rx_post_divider, sw_post_divider, mclk_source, aux_source, pll_post_divider;
  int          n_errors, comparisons;

  srp_host_model host (.core_clk, .reg_index, .reg_wdata, .reg_write, .reg_read, .reg_rdata);

  srp_routing_power DUT (.core_clk, .resetn, .reg_index, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .receive_input, .cdr_data, .receiver_enable, .stream_present, .rx_lock,
    .rx_n, .rx_k, .rx_post_divider, .recovered_data, .sw_n, .sw_k, .sw_post_divider,
    .mclk_pin_is_output, .mclk_source, .aux_clock_enable, .aux_source, .audio_port_data,
    .transmit_data, .transmit_encode_clock_sel, .transmitter_enable, .oscillator_enable,
    .pll_enable, .mclk_use_oscillator, .aux_use_oscillator, .output_clocks_valid,
    .pll_auto_mode, .pll_n, .pll_k, .pll_post_divider);

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Case comparison so an unknown never counts as a match
  task automatic check(input string name, input logic [21:0] exp, input logic [21:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(idx, d);
    check("reg_rdata", 22'(exp), 22'(d));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic chk_pll(input logic [3:0] n, input logic [21:0] k, input logic [1:0] pd,
                         input logic v);
    check("pll_n", 22'(n), 22'(pll_n));
    check("pll_k", k, pll_k);
    check("pll_post_divider", 22'(pd), 22'(pll_post_divider));
    check("output_clocks_valid", 22'(v), 22'(output_clocks_valid));
  endtask

  task automatic chk_power(input logic [7:0] v);
    check("pll_enable", 22'(!v[srp_pkg::PLL_POWERDOWN_BIT]), 22'(pll_enable));
    check("transmitter_enable", 22'(!v[srp_pkg::TXPD_BIT]), 22'(transmitter_enable));
    check("oscillator_enable", 22'(!v[srp_pkg::OSCILLATOR_POWERDOWN_BIT]), 22'(oscillator_enable));
  endtask

  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: a run that overstays its bound is a failure
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    {core_clk, resetn, receiver_enable, stream_present, rx_lock, recovered_data} = 6'h00;
    {mclk_pin_is_output, aux_clock_enable, audio_port_data} = 3'h0;
    {receive_input, rx_n, rx_k, rx_post_divider} = 36'h0;
    {sw_n, sw_k, sw_post_divider, mclk_source, aux_source} = 32'h0;
    repeat (16) @(posedge core_clk);
    #10;
    chk_power(srp_pkg::PWR_RST);
    check("transmit_encode_clock_sel", 22'h1, 22'(transmit_encode_clock_sel));
    resetn = 1'b1;
    rd(srp_pkg::REG_RX_INPUT_SEL, 8'h00);
    rd(srp_pkg::REG_TX_CTRL_FOUR, 8'h40);
    rd(srp_pkg::REG_POWER_DOWN, 8'h0d);
    // Reserved bits, unmapped index and soft reset
    host.write_reg(srp_pkg::REG_RX_INPUT_SEL, 8'hff);
    rd(srp_pkg::REG_RX_INPUT_SEL, 8'h07);
    host.write_reg(srp_pkg::REG_TX_CTRL_FOUR, 8'hbf);
    rd(srp_pkg::REG_TX_CTRL_FOUR, 8'h00);
    host.write_reg(srp_pkg::REG_POWER_DOWN, 8'hf2);
    rd(srp_pkg::REG_POWER_DOWN, 8'h00);
    host.write_reg(7'h10, 8'hff);
    rd(7'h10, 8'h00);
    host.write_reg(srp_pkg::REG_SOFT_RESET, 8'h5a);
    rd(srp_pkg::REG_POWER_DOWN, 8'h0d);
    rd(srp_pkg::REG_TX_CTRL_FOUR, 8'h40);
    // Oscillator first, then transmitter, then PLL
    for (int i = 0; i < 3; i++)
    begin
      pw = (i == 0) ? 8'h05 : ((i == 1) ? 8'h01 : 8'h00);
      host.write_reg(srp_pkg::REG_POWER_DOWN, pw);
      chk_power(pw);
    end
    // Oscillator offered to both clock outputs only for source code zero
    {mclk_pin_is_output, aux_clock_enable} = 2'b11;
    for (int s = 0; s < 3; s++)
    begin
      mclk_source = 2'(s);
      aux_source = 2'(s);
      settle(1);
      check("mclk_use_oscillator", 22'(s == 0), 22'(mclk_use_oscillator));
      check("aux_use_oscillator", 22'(s == 0), 22'(aux_use_oscillator));
    end
    // Each code picks exactly one pin: 2 sync flops plus the output register
    for (int i = 0; i < 8; i++)
    begin
      receive_input = 8'h01 << i;
      host.write_reg(srp_pkg::REG_RX_INPUT_SEL, 8'(i));
      settle(3);
      check("cdr_data", 22'h1, 22'(cdr_data));
      receive_input = ~(8'h01 << i);
      settle(3);
      check("cdr_data", 22'h0, 22'(cdr_data));
    end
    // Source changes made with the transmitter powered down
    for (int s = 0; s < 2; s++)
    begin
      host.write_reg(srp_pkg::REG_POWER_DOWN, 8'h04);
      host.write_reg(srp_pkg::REG_TX_CTRL_FOUR, s ? 8'h40 : 8'h00);
      host.write_reg(srp_pkg::REG_POWER_DOWN, 8'h00);
      check("transmit_encode_clock_sel", 22'(s), 22'(transmit_encode_clock_sel));
      for (int b = 0; b < 2; b++)
      begin
        recovered_data = b[0];
        audio_port_data = ~b[0];
        settle(2);
        check("transmit_data", 22'(b[0] ^ s[0]), 22'(transmit_data));
      end
    end
    audio_port_data = 1'b1;
    host.write_reg(srp_pkg::REG_POWER_DOWN, 8'h04);
    settle(2);
    check("transmit_data", 22'h0, 22'(transmit_data));
    // Manual factors, then automatic default, tracking, relock and freeze
    {sw_n, sw_k, sw_post_divider} = {4'h5, 22'h12345, 2'h1};
    settle(3);
    check("pll_auto_mode", 22'h0, 22'(pll_auto_mode));
    chk_pll(4'h5, 22'h12345, 2'h1, 1'b1);
    {rx_n, rx_k, rx_post_divider} = {4'h9, 22'h2aaaa, 2'h3};
    receiver_enable = 1'b1;
    settle(3);
    check("pll_auto_mode", 22'h1, 22'(pll_auto_mode));
    chk_pll(4'h8, 22'h0, 2'h2, 1'b0);
    stream_present = 1'b1;
    settle(3);
    chk_pll(4'h9, 22'h2aaaa, 2'h3, 1'b0);
    rx_lock = 1'b1;
    settle(3);
    chk_pll(4'h9, 22'h2aaaa, 2'h3, 1'b1);
    {rx_n, rx_lock} = {4'ha, 1'b0};
    settle(3);
    chk_pll(4'ha, 22'h2aaaa, 2'h3, 1'b0);
    rx_lock = 1'b1;
    settle(3);
    {stream_present, rx_n, rx_k, rx_post_divider} = {1'b0, 4'hc, 22'h15555, 2'h0};
    settle(3);
    chk_pll(4'ha, 22'h2aaaa, 2'h3, 1'b1);
    // Stream returns: frozen factors give way to the new receiver values
    stream_present = 1'b1;
    settle(3);
    chk_pll(4'hc, 22'h15555, 2'h0, 1'b1);
    finish_test();
  end
endmodule // srp_routing_power_tb
